// ---- hdl/vic_pkg.sv ----
// Constants, field layouts and state carrier of the vectored interrupt block
package vic_pkg;

	// Source count and nesting depth
	localparam int          VIC_NUM_SRC     = 32;
	localparam int          VIC_STACK_DEPTH = 8;
	localparam logic [3:0]  VIC_STACK_FULL  = 4'h8;
	localparam logic [3:0]  VIC_STACK_ONE   = 4'h1;

	// Absolute byte addresses of the register map
	localparam logic [31:0] VIC_SMR_BASE    = 32'hFFFF_F000; // 32 mode regs
	localparam logic [31:0] VIC_SVR_BASE    = 32'hFFFF_F080; // 32 handler regs
	localparam logic [31:0] VIC_NVR_ADDR    = 32'hFFFF_F100; // Normal vector
	localparam logic [31:0] VIC_FVR_ADDR    = 32'hFFFF_F104; // Fast vector
	localparam logic [31:0] VIC_CUR_ADDR    = 32'hFFFF_F108; // Current source
	localparam logic [31:0] VIC_PEND_ADDR   = 32'hFFFF_F10C; // Pending image
	localparam logic [31:0] VIC_MASK_ADDR   = 32'hFFFF_F110; // Enable mask
	localparam logic [31:0] VIC_CORE_ADDR   = 32'hFFFF_F114; // Request image
	localparam logic [31:0] VIC_IEN_ADDR    = 32'hFFFF_F120; // Enable command
	localparam logic [31:0] VIC_IDIS_ADDR   = 32'hFFFF_F124; // Disable command
	localparam logic [31:0] VIC_PSET_ADDR   = 32'hFFFF_F128; // Pending set
	localparam logic [31:0] VIC_PCLR_ADDR   = 32'hFFFF_F12C; // Pending clear
	localparam logic [31:0] VIC_EOS_ADDR    = 32'hFFFF_F130; // End of service
	localparam logic [31:0] VIC_FFEN_ADDR   = 32'hFFFF_F140; // Redirect enable
	localparam logic [31:0] VIC_FFDIS_ADDR  = 32'hFFFF_F144; // Redirect disable
	localparam logic [31:0] VIC_FFST_ADDR   = 32'hFFFF_F148; // Redirect status

	// Window decode: bits above the 32-word window
	localparam int          VIC_WIN_LSB     = 7;
	localparam int          VIC_IDX_LSB     = 2;

	// Mode register field layout
	localparam int          VIC_PRIO_LSB    = 0;
	localparam int          VIC_TRIG_LSB    = 5;

	// Trigger type codes
	localparam logic [1:0]  VIC_TRIG_LOW    = 2'h0;
	localparam logic [1:0]  VIC_TRIG_FALL   = 2'h1;
	localparam logic [1:0]  VIC_TRIG_HIGH   = 2'h2;
	localparam logic [1:0]  VIC_TRIG_RISE   = 2'h3;

	// Answers and fixed values
	localparam logic [1:0]  VIC_RESP_OKAY   = 2'h0;
	localparam logic [31:0] VIC_SPUR_VECTOR = 32'h0000_0000;
	localparam logic [31:0] VIC_NORMAL_MASK = 32'hFFFF_FFFE;

	// One nesting stack entry
	typedef struct packed {
		logic [4:0] src;
		logic [2:0] prio;
	} vic_entry_t;

	// Result of the priority search
	typedef struct packed {
		logic       found;
		logic [4:0] idx;
	} vic_pick_t;

	// Complete state of the controller
	typedef struct packed {
		logic [31:0]       sync1;
		logic [31:0]       sync2;
		logic [31:0]       prev;
		logic [31:0]       edge_latch;
		logic [31:0]       enable;
		logic [31:0]       forced;
		logic [31:0][2:0]  prio;
		logic [31:0][1:0]  trig;
		logic [31:0][31:0] handler;
		vic_entry_t [7:0]  stack;
		logic [3:0]        depth;
		logic              aw_have;
		logic              w_have;
		logic [31:0]       aw_addr;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic              normal_int_request_n_n;
		logic              fast_int_request_n_n;
	} vic_state_t;

endpackage : vic_pkg

// ---- hdl/vic_ctrl.sv ----
// Vectored priority interrupt controller with AXI4-Lite register slave

`timescale 1ns/1ps

module vic_ctrl
	import vic_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address channel
	input  wire logic [31:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// AXI4-Lite write data channel
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response channel
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read address channel
	input  wire logic [31:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// AXI4-Lite read data channel
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Interrupt source pins, bit 0 is the fast source
	input  wire logic [31:0] int_src,
	// Requests to the processor core, active low
	output logic             normal_int_request_n,
	output logic             fast_int_request_n
);

	// State register and its next value
	vic_state_t q;
	vic_state_t next_q;

	// Combinational helpers
	logic [31:0] pend;       // Effective pending per source
	logic [31:0] cand;       // Normal candidates for the resolver
	logic [31:0] clr;        // Pending clears this cycle
	logic [31:0] setv;       // Pending sets this cycle
	logic [31:0] edge_mask;  // Sources programmed edge-triggered
	logic [2:0]  cur_level;  // Level of the current interrupt
	logic        busy;       // An interrupt is being serviced
	vic_pick_t   pick;       // Best candidate at this moment
	logic        wr_fire;    // Write carried out this cycle
	logic        rd_fire;    // Read accepted this cycle
	logic        nvr_read;   // Normal vector read this cycle
	logic [31:0] wmask;      // Byte lanes of the pending write
	int          i;          // Loop index

	// True when the trigger code is an edge type
	function automatic logic is_edge(input logic [1:0] t);
		is_edge = (t == VIC_TRIG_RISE) || (t == VIC_TRIG_FALL);
	endfunction : is_edge

	// True when a sampled level matches the trigger code's active level
	function automatic logic level_hit(input logic [1:0] t, input logic v);
		level_hit = (t == VIC_TRIG_HIGH) ? v : ~v;
	endfunction : level_hit

	// True when the address falls in the 32-word window at base
	function automatic logic in_window(input logic [31:0] a,
		input logic [31:0] base);
		in_window = (a[31:VIC_WIN_LSB] == base[31:VIC_WIN_LSB]);
	endfunction : in_window

	// Any candidate strictly above the current level, or any when idle
	function automatic logic wants_irq(input logic [31:0] c,
		input logic [31:0][2:0] p, input logic act, input logic [2:0] lvl);
		wants_irq = 1'b0;
		for (int k = 1; k < VIC_NUM_SRC; k++) begin
			if (c[k] && (!act || p[k] > lvl)) begin
				wants_irq = 1'b1;
			end
		end
	endfunction : wants_irq

	// Highest priority candidate; downward scan makes lowest index win ties
	function automatic vic_pick_t select_best(input logic [31:0] c,
		input logic [31:0][2:0] p);
		logic [2:0] best;
		best = 3'h0;
		select_best = '0;
		for (int k = VIC_NUM_SRC - 1; k >= 1; k--) begin
			if (c[k] && (!select_best.found || p[k] >= best)) begin
				select_best.found = 1'b1;
				select_best.idx   = 5'(k);
				best              = p[k];
			end
		end
	endfunction : select_best

	// Next-state logic for the whole block
	always_comb begin
		next_q   = q;
		clr      = '0;
		setv     = '0;
		nvr_read = 1'b0;
		wmask    = '0;

		// Two-flop synchronisers, then an edge reference stage
		next_q.sync1 = int_src;
		next_q.sync2 = q.sync1;
		next_q.prev  = q.sync2;

		// Per-source pending and edge capture
		for (i = 0; i < VIC_NUM_SRC; i++) begin
			edge_mask[i] = is_edge(q.trig[i]);
			if (edge_mask[i]) begin
				// Edge types read the latch
				pend[i] = q.edge_latch[i];
				if (q.trig[i] == VIC_TRIG_RISE) begin
					setv[i] = q.sync2[i] & ~q.prev[i];
				end else begin
					setv[i] = ~q.sync2[i] & q.prev[i];
				end
			end else begin
				// Level types follow the pin; software clears at the source
				pend[i] = level_hit(q.trig[i], q.sync2[i]);
			end
		end

		// Normal candidates exclude source 0 and redirected sources
		cand = pend & q.enable & ~q.forced & VIC_NORMAL_MASK;
		busy = (q.depth != 4'h0);
		cur_level = busy ? q.stack[3'(q.depth - VIC_STACK_ONE)].prio : 3'h0;
		pick = select_best(cand, q.prio);

		// Write address and data are taken in either order
		if (awvalid && q.awready) begin
			next_q.aw_have = 1'b1;
			next_q.aw_addr = awaddr;
		end
		if (wvalid && q.wready) begin
			next_q.w_have = 1'b1;
			next_q.w_data = wdata;
			next_q.w_strb = wstrb;
		end
		// Response leaves once the master accepts it
		if (q.bvalid && bready) begin
			next_q.bvalid = 1'b0;
		end
		if (q.rvalid && rready) begin
			next_q.rvalid = 1'b0;
		end

		// Read: decode, answer and side effects at acceptance
		rd_fire = arvalid && q.arready;
		if (rd_fire) begin
			next_q.rvalid = 1'b1;
			next_q.rdata  = '0;
			if (araddr == VIC_NVR_ADDR) begin
				nvr_read = 1'b1;
				next_q.rdata = VIC_SPUR_VECTOR;
				if (pick.found && (!busy || q.prio[pick.idx] > cur_level)
					&& q.depth != VIC_STACK_FULL) begin
					// Take the new interrupt and nest it
					next_q.stack[q.depth[2:0]].src  = pick.idx;
					next_q.stack[q.depth[2:0]].prio = q.prio[pick.idx];
					next_q.depth = q.depth + VIC_STACK_ONE;
					next_q.rdata = q.handler[pick.idx];
					// Redirected sources never reach the pick
					clr[pick.idx] = edge_mask[pick.idx];
				end
			end else if (araddr == VIC_FVR_ADDR) begin
				next_q.rdata = q.handler[0];
				clr[0] = edge_mask[0];
			end else if (araddr == VIC_CUR_ADDR) begin
				next_q.rdata = busy ?
					{27'h0, q.stack[3'(q.depth - VIC_STACK_ONE)].src} : '0;
			end else if (araddr == VIC_PEND_ADDR) begin
				next_q.rdata = pend;
			end else if (araddr == VIC_MASK_ADDR) begin
				next_q.rdata = q.enable;
			end else if (araddr == VIC_CORE_ADDR) begin
				next_q.rdata = {30'h0, ~q.fast_int_request_n_n, ~q.normal_int_request_n_n};
			end else if (araddr == VIC_FFST_ADDR) begin
				next_q.rdata = q.forced;
			end else if (in_window(araddr, VIC_SMR_BASE)) begin
				// Source zero's priority reads back though unused
				next_q.rdata[VIC_TRIG_LSB +: 2] =
					q.trig[araddr[VIC_IDX_LSB +: 5]];
				next_q.rdata[VIC_PRIO_LSB +: 3] =
					q.prio[araddr[VIC_IDX_LSB +: 5]];
			end else if (in_window(araddr, VIC_SVR_BASE)) begin
				next_q.rdata = q.handler[araddr[VIC_IDX_LSB +: 5]];
			end
		end

		// Write: performed once both address and data are held
		wr_fire = q.aw_have && q.w_have && !q.bvalid;
		if (wr_fire) begin
			next_q.aw_have = 1'b0;
			next_q.w_have  = 1'b0;
			next_q.bvalid  = 1'b1;
			for (i = 0; i < 4; i++) begin
				wmask[i*8 +: 8] = {8{q.w_strb[i]}};
			end
			if (q.aw_addr == VIC_IEN_ADDR) begin
				next_q.enable = q.enable | q.w_data;
			end else if (q.aw_addr == VIC_IDIS_ADDR) begin
				next_q.enable = q.enable & ~q.w_data;
			end else if (q.aw_addr == VIC_PSET_ADDR) begin
				setv = setv | (q.w_data & edge_mask);
			end else if (q.aw_addr == VIC_PCLR_ADDR) begin
				clr = clr | (q.w_data & edge_mask);
			end else if (q.aw_addr == VIC_EOS_ADDR) begin
				if (next_q.depth != 4'h0) begin
					next_q.depth = next_q.depth - VIC_STACK_ONE;
				end
			end else if (q.aw_addr == VIC_FFEN_ADDR) begin
				next_q.forced = (q.forced | q.w_data) & VIC_NORMAL_MASK;
			end else if (q.aw_addr == VIC_FFDIS_ADDR) begin
				next_q.forced = q.forced & ~q.w_data;
			end else if (in_window(q.aw_addr, VIC_SMR_BASE)) begin
				if (q.w_strb[0]) begin
					next_q.prio[q.aw_addr[VIC_IDX_LSB +: 5]] =
						q.w_data[VIC_PRIO_LSB +: 3];
					next_q.trig[q.aw_addr[VIC_IDX_LSB +: 5]] =
						q.w_data[VIC_TRIG_LSB +: 2];
				end
			end else if (in_window(q.aw_addr, VIC_SVR_BASE)) begin
				next_q.handler[q.aw_addr[VIC_IDX_LSB +: 5]] =
					(q.handler[q.aw_addr[VIC_IDX_LSB +: 5]] & ~wmask)
					| (q.w_data & wmask);
			end
		end

		// Pending latch: a new edge beats a clear in the same cycle
		next_q.edge_latch = ((q.edge_latch & ~clr) | setv) & edge_mask;

		// Channel readies for the coming cycle
		next_q.awready = !next_q.aw_have && !next_q.bvalid;
		next_q.wready  = !next_q.w_have && !next_q.bvalid;
		next_q.arready = !next_q.rvalid;

		// Normal request judged against the level after push or pop
		next_q.normal_int_request_n_n = ~(wants_irq(cand & ~clr, q.prio,
			next_q.depth != 4'h0,
			next_q.stack[3'(next_q.depth - VIC_STACK_ONE)].prio)
			&& !nvr_read);

		// Fast request bypasses all resolution
		next_q.fast_int_request_n_n = ~((pend[0] & q.enable[0] & ~clr[0])
			| (|(pend & q.enable & q.forced)));
	end

	// State register with synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q        <= '0;
			q.normal_int_request_n_n <= 1'b1;
			q.fast_int_request_n_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from the state register; bresp and rresp fixed at okay
	assign awready              = q.awready;
	assign wready               = q.wready;
	assign bvalid               = q.bvalid;
	assign bresp                = VIC_RESP_OKAY;
	assign arready              = q.arready;
	assign rvalid               = q.rvalid;
	assign rdata                = q.rdata;
	assign rresp                = VIC_RESP_OKAY;
	assign normal_int_request_n = q.normal_int_request_n_n;
	assign fast_int_request_n   = q.fast_int_request_n_n;

endmodule : vic_ctrl

// ---- verification/vic_chk_assertions.sv ----
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
module vic_chk
	import vic_pkg::*;
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write channels
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	// Read channels
	input wire logic [31:0] araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// Requests to the core
	input wire logic        normal_int_request_n,
	input wire logic        fast_int_request_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Both requests idle on the first edge out of reset
	rst_idle_a: assert property (
		$rose(aresetn) |-> normal_int_request_n && fast_int_request_n)
		else $error("request active right after reset");
	// Taking a normal vector releases the request line
	nvr_release_a: assert property (
		arvalid && arready && araddr == VIC_NVR_ADDR &&
		!normal_int_request_n |-> ##[1:2] normal_int_request_n)
		else $error("normal request held after vector read");
	// Read answered one cycle after the address is taken
	rd_answer_a: assert property (
		arvalid && arready |=> rvalid)
		else $error("read data late");
	// Read data stands until taken
	rd_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped or changed");
	// Write answered on the second edge after both are taken
	wr_answer_a: assert property (
		awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	// No new write taken while a response waits
	wr_block_a: assert property (
		bvalid |-> !awready && !wready)
		else $error("write taken during response");
	// No new read taken while read data waits
	rd_block_a: assert property (
		rvalid |-> !arready)
		else $error("read taken during read data");
	// Responses always report success
	resp_okay_a: assert property (
		(bvalid || rvalid) |-> bresp == VIC_RESP_OKAY &&
		rresp == VIC_RESP_OKAY)
		else $error("response not okay");
endmodule : vic_chk

bind vic_ctrl vic_chk vic_chk_inst (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
	.arready, .rdata, .rresp, .rvalid, .rready, .normal_int_request_n,
	.fast_int_request_n);

// ---- verification/vic_src_model.sv ----
// Peripheral pins feeding the interrupt sources
`timescale 1ns/1ps
module vic_src_model (
	// Clock
	input wire logic        aclk,
	// Source pins
	output logic     [31:0] int_src
);
	// All pins low at start
	initial int_src = 32'h0;

	// Move one pin just after a clock edge
	task drive(input int i, input logic v);
		@(posedge aclk);
		int_src[i] <= v;
	endtask : drive

	// Handler removes a level condition at its origin
	task settle(input int i, input logic idle);
		drive(i, idle);
	endtask : settle
endmodule : vic_src_model

// ---- verification/vic_tb_top.sv ----
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vectored_priority_interrupt_ctrl_tb_top;
	import vic_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata, int_src;
	logic [31:0] hnd [32];  // Handler values
	logic [31:0] exp_q [$]; // Expected read data
	logic [1:0]  bresp, rresp, t;
	logic        awready, wready, bvalid, arready, rvalid, act, edg;
	logic        normal_int_request_n, fast_int_request_n;
	int          mismatches, checked, m, seed;

	vic_ctrl vic_ctrl_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0),
		.awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .int_src,
		.normal_int_request_n, .fast_int_request_n);
	vic_src_model vic_src_model_inst (.aclk, .int_src);

	// Clock at 40 MHz
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			mismatches++;
			$display("ERROR %0t: got %h want %h", $time, seen, want);
		end
	endtask : check

	// Verdict and end of run
	task complete_run;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	// A wait ran out
	task timeout;
		mismatches++;
		complete_run();
	endtask : timeout

	// Oldest note against each read beat
	always @(posedge aclk)
		if (rvalid && rready)
			check(rdata, exp_q.pop_front());

	// Register write, address and data offered together
	task wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		bready <= 1'b0;
		if (n == 40) timeout();
	endtask : wr

	// Register read, expected data noted first
	task rd(input logic [31:0] a, input logic [31:0] e);
		int n;
		int k;
		@(posedge aclk);
		k = $random(seed) & 3; // Random delay before rready rises
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (k == 0);
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (n + 1 >= k) rready <= 1'b1;
		end
		rready <= 1'b0;
		if (n == 40) timeout();
	endtask : rd

	// Pick fast or normal request
	function logic req(input logic f);
		return f ? fast_int_request_n : normal_int_request_n;
	endfunction : req

	// Wait for a request level, bounded
	task wait_req(input logic f, input logic v);
		int n;
		for (n = 0; n < 12; n++) begin
			@(posedge aclk);
			if (req(f) === v) break;
		end
		check({31'h0, req(f)}, {31'h0, v});
		if (n == 12) timeout();
	endtask : wait_req

	// Request must still show this level after settling
	task stay(input logic f, input logic v);
		repeat (8) @(posedge aclk);
		check({31'h0, req(f)}, {31'h0, v});
	endtask : stay

	// Mode word from trigger code and priority
	function logic [31:0] md(input logic [1:0] tt, input logic [2:0] p);
		return {25'h0, tt, 2'h0, p};
	endfunction : md

	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		seed = 32'hCD12B43B;
		mismatches = 0;
		checked = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (m = 0; m < 32; m++) begin
			hnd[m] = $random(seed);
			wr(VIC_SVR_BASE + 32'(4 * m), hnd[m]);
		end
		rd(VIC_SVR_BASE + 32'h8, hnd[2]);
		rd(32'hFFFF_F1F0, 32'h0);
		rd(VIC_NVR_ADDR, VIC_SPUR_VECTOR);
		// Fast source through all four trigger codes
		for (m = 0; m < 4; m++) begin
			t = 2'(m);
			act = (t == VIC_TRIG_HIGH || t == VIC_TRIG_RISE);
			edg = (t == VIC_TRIG_FALL || t == VIC_TRIG_RISE);
			wr(VIC_SMR_BASE, md(t, 3'(m + 4)));
			rd(VIC_SMR_BASE, md(t, 3'(m + 4)));
			vic_src_model_inst.drive(0, !act);
			wr(VIC_PCLR_ADDR, 32'h1);
			wr(VIC_IEN_ADDR, 32'h1);
			rd(VIC_MASK_ADDR, 32'h1);
			vic_src_model_inst.drive(0, act);
			wait_req(1'b1, 1'b0);
			check({31'h0, normal_int_request_n}, 32'h1);
			rd(VIC_FVR_ADDR, hnd[0]);
			if (edg) wait_req(1'b1, 1'b1);
			else stay(1'b1, 1'b0);
			vic_src_model_inst.drive(0, !act);
			wait_req(1'b1, 1'b1);
			wr(VIC_IDIS_ADDR, 32'h1);
			rd(VIC_MASK_ADDR, 32'h0);
		end
		// Nesting: 3 and 9 high level prio 2, 5 and 7 rising prio 6
		wr(VIC_SMR_BASE + 32'hC, md(VIC_TRIG_HIGH, 3'h2));
		wr(VIC_SMR_BASE + 32'h14, md(VIC_TRIG_RISE, 3'h6));
		wr(VIC_SMR_BASE + 32'h1C, md(VIC_TRIG_RISE, 3'h6));
		wr(VIC_SMR_BASE + 32'h24, md(VIC_TRIG_HIGH, 3'h2));
		wr(VIC_IEN_ADDR, 32'h2A8);
		vic_src_model_inst.drive(3, 1'b1);
		wait_req(1'b0, 1'b0);
		rd(VIC_NVR_ADDR, hnd[3]);
		wait_req(1'b0, 1'b1);
		vic_src_model_inst.drive(9, 1'b1);
		stay(1'b0, 1'b1);
		vic_src_model_inst.drive(5, 1'b1);
		vic_src_model_inst.drive(7, 1'b1);
		wait_req(1'b0, 1'b0);
		rd(VIC_NVR_ADDR, hnd[5]);
		rd(VIC_CUR_ADDR, 32'h5);
		stay(1'b0, 1'b1);
		rd(VIC_PEND_ADDR, 32'hFFFF_FFDE);
		wr(VIC_EOS_ADDR, 32'h0);
		wait_req(1'b0, 1'b0);
		rd(VIC_NVR_ADDR, hnd[7]);
		wr(VIC_EOS_ADDR, 32'h0);
		stay(1'b0, 1'b1);
		vic_src_model_inst.settle(3, 1'b0);
		wr(VIC_EOS_ADDR, 32'h0);
		wait_req(1'b0, 1'b0);
		rd(VIC_NVR_ADDR, hnd[9]);
		vic_src_model_inst.settle(9, 1'b0);
		wr(VIC_EOS_ADDR, 32'h0);
		// Software set and clear
		wr(VIC_PSET_ADDR, 32'h8);
		stay(1'b0, 1'b1);
		wr(VIC_PSET_ADDR, 32'h20);
		wait_req(1'b0, 1'b0);
		wr(VIC_PCLR_ADDR, 32'h20);
		wait_req(1'b0, 1'b1);
		// Redirected source
		wr(VIC_FFEN_ADDR, 32'h20);
		wr(VIC_PSET_ADDR, 32'h20);
		wait_req(1'b1, 1'b0);
		rd(VIC_CORE_ADDR, 32'h2);
		rd(VIC_NVR_ADDR, VIC_SPUR_VECTOR);
		rd(VIC_PEND_ADDR, 32'hFFFF_FD76);
		rd(VIC_FFST_ADDR, 32'h20);
		// Redirect removed: latched source moves to the normal path
		wr(VIC_FFDIS_ADDR, 32'h20);
		wait_req(1'b1, 1'b1);
		wait_req(1'b0, 1'b0);
		wr(VIC_PCLR_ADDR, 32'h20);
		wait_req(1'b0, 1'b1);
		complete_run();
	end
endmodule : vectored_priority_interrupt_ctrl_tb_top
